// File: remote_source.sv
/* Remote trail source: one trace byte every fourth cycle while run is high.
   Assumes the sink samples the byte with frame_en. */
`timescale 1ns/10ps
module remote_source (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         run,
    input  wire logic [127:0] trace,
    output logic              frame_en,
    output logic [7:0]        tbyte
);
    logic [3:0] pos_q;
    logic [1:0] gap_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos_q    <= 4'h0;
            gap_q    <= 2'h0;
            frame_en <= 1'b0;
            tbyte    <= 8'h00;
        end else begin
            gap_q    <= gap_q + 2'h1;
            frame_en <= run && gap_q == 2'h0;
            if (run && gap_q == 2'h0) begin
                tbyte <= trace[8*pos_q +: 8];
                pos_q <= pos_q + 4'h1;
            end else begin
                tbyte <= ~tbyte; // Stale byte must not look valid
            end
        end
    end
endmodule : remote_source

// File: trace_crc7.sv
/*
 * Check code of a trace string: header byte with zero check bits followed by
 * the fifteen identifier bytes, first bit most significant.
 * Assumes the identifier is static, so the long combinational loop is fine.
 */
`timescale 1ns/10ps
module trace_crc7 (
    input  wire logic [trace_sup_pkg::ID_BITS-1:0] identifier,
    output logic      [trace_sup_pkg::CRC_W-1:0]   crc
);

    function automatic logic [6:0] crc7_of(input logic [127:0] bits);
        logic [6:0] rem;
        logic       fb;
        rem = 7'h00;
        for (int i = 127; i >= 0; i--) begin
            fb  = rem[6] ^ bits[i];
            rem = {rem[5:0], 1'b0};
            if (fb) begin
                rem = rem ^ trace_sup_pkg::CRC_POLY;
            end
        end
        return rem;
    endfunction : crc7_of

    // Shift-register form gives the remainder of the string times x^7
    always_comb begin
        crc = crc7_of({trace_sup_pkg::HEADER_MARK, 7'h00, identifier});
    end

endmodule : trace_crc7

// File: trace_rx_capture.sv
/*
 * Receive trace capture: aligns on the header byte and stores the accepted
 * string, or replicates a single repeating byte when no expectation is set.
 * Assumes one trace byte per frame strobe.
 */
`timescale 1ns/10ps
module trace_rx_capture (
    input  wire logic hclk,
    input  wire logic hresetn,
    trace_rx_if.capture rx
);

    logic [3:0] pos_q;
    logic [3:0] pos_d;

    always_comb begin
        if (rx.trace_byte[7] == trace_sup_pkg::HEADER_MARK) begin
            pos_d = 4'h0;
        end else begin
            pos_d = pos_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos_q <= 4'h0;
        end else if (rx.frame_en) begin
            pos_q <= pos_d + 4'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx.changed <= 1'b0;
            for (int i = 0; i < trace_sup_pkg::TRACE_LEN; i++) begin
                rx.accepted[i] <= trace_sup_pkg::BYTE_ZERO;
            end
        end else begin
            rx.changed <= 1'b0;
            if (rx.frame_en) begin
                if (rx.repeat_mode) begin
                    // Old sources send one byte over and over
                    for (int i = 0; i < trace_sup_pkg::TRACE_LEN; i++) begin
                        rx.accepted[i] <= rx.trace_byte;
                    end
                    rx.changed <= rx.accepted[0] != rx.trace_byte;
                end else begin
                    rx.accepted[pos_d] <= rx.trace_byte;
                    rx.changed         <= rx.accepted[pos_d] != rx.trace_byte;
                end
            end
        end
    end

endmodule : trace_rx_capture

// File: trace_rx_if.sv
/*
 * Carrier between the top and the receive trace capture: received trace
 * bytes per frame, the repeat mode and the accepted trace.
 * Assumes both ends run on the one system clock.
 */
`timescale 1ns/10ps
interface trace_rx_if;
    logic       frame_en;
    logic [7:0] trace_byte;
    logic       repeat_mode;
    logic [7:0] accepted [trace_sup_pkg::TRACE_LEN];
    logic       changed;

    modport top     (output frame_en, output trace_byte, output repeat_mode,
                     input accepted, input changed);
    modport capture (input frame_en, input trace_byte, input repeat_mode,
                     output accepted, output changed);
endinterface : trace_rx_if

// File: trace_sup_chk.sv
/* Port checker for the trail trace block.
   Assumes the transmit position counts from zero after reset. */
`timescale 1ns/10ps
module trace_sup_chk (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       tx_frame_en,
    input wire logic [7:0] client_signal_label,
    input wire logic [7:0] tx_trace_byte,
    input wire logic [7:0] tx_trail_signal_label,
    input wire logic [7:0] tx_operator_byte,
    input wire logic       tx_idle_unequipped_signal,
    input wire logic       rx_frame_en,
    input wire logic [7:0] rx_trail_signal_label,
    input wire logic       rx_remote_error_indication,
    input wire logic       trace_mismatch_report,
    input wire logic       remote_defect_report,
    input wire logic       signal_loss_unequipped,
    input wire logic       far_end_error_pulse
);
    logic [3:0] pos_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) pos_q <= 4'h0;
        else if (tx_frame_en) pos_q <= pos_q + 4'h1;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not zero-wait okay");
    idle_unequipped_signal_label_a: assert property (rx_frame_en |=> signal_loss_unequipped == ($past(rx_trail_signal_label) == 8'h00))
        else $error("unequipped flag does not follow label");
    suppress_a: assert property (signal_loss_unequipped |-> !trace_mismatch_report && !remote_defect_report)
        else $error("report not suppressed while unequipped");
    fe_skip_a: assert property (rx_frame_en && rx_trail_signal_label == 8'h00 |=> !far_end_error_pulse)
        else $error("far-end count while unequipped");
    fe_pulse_a: assert property (rx_frame_en && rx_remote_error_indication && rx_trail_signal_label != 8'h00
                                 |=> far_end_error_pulse)
        else $error("far-end error pulse missing");
    tx_hold_a: assert property (!tx_frame_en |=> $stable(tx_trace_byte) && $stable(tx_idle_unequipped_signal))
        else $error("transmit byte moved without frame");
    id_msb_a: assert property (tx_frame_en ##1 tx_trace_byte != 8'h00 |-> tx_trace_byte[7] == ($past(pos_q) == 4'h0))
        else $error("trace byte top bit wrong for position");
    idle_zero_a: assert property (tx_idle_unequipped_signal |-> tx_trail_signal_label == 8'h00 && tx_operator_byte == 8'h00)
        else $error("idle container label or operator byte not zero");
    label_pass_a: assert property (tx_frame_en ##1 !tx_idle_unequipped_signal |-> tx_trail_signal_label == $past(client_signal_label))
        else $error("connected label not passed through");
endmodule : trace_sup_chk
bind trail_trace_and_unequipped_supervision trace_sup_chk chk_i (.hclk, .hresetn, .hreadyout, .hresp, .tx_frame_en,
    .client_signal_label, .tx_trace_byte, .tx_trail_signal_label, .tx_operator_byte, .tx_idle_unequipped_signal,
    .rx_frame_en, .rx_trail_signal_label, .rx_remote_error_indication, .trace_mismatch_report, .remote_defect_report,
    .signal_loss_unequipped, .far_end_error_pulse);

// File: trace_sup_pkg.sv
/*
 * Shared constants for trail trace and unequipped supervision: register
 * word indices, control and event bit positions, trace layout, check code.
 * Assumes a 32-bit AHB-Lite register bus with one word per register.
 */
package trace_sup_pkg;

    localparam int           TRACE_LEN     = 16;
    localparam int           TRACE_WORDS   = 4;
    localparam int           CRC_W         = 7;
    localparam int           ID_BITS       = 120;
    localparam int           EV_W          = 3;

    localparam logic [5:0]   IDX_CTRL      = 6'h00;
    localparam logic [5:0]   IDX_STATUS    = 6'h01;
    localparam logic [5:0]   IDX_MASK      = 6'h02;
    localparam logic [5:0]   IDX_STATE     = 6'h03;
    localparam logic [5:0]   IDX_TX_BASE   = 6'h04;
    localparam logic [5:0]   IDX_EXP_BASE  = 6'h08;
    localparam logic [5:0]   IDX_ACC_BASE  = 6'h0c;

    localparam int           CTRL_EXPECT   = 0;
    localparam int           CTRL_CONNECT  = 1;
    localparam int           CTRL_INSTALL  = 2;
    localparam int           CTRL_SUPER    = 3;
    localparam int           CTRL_W        = 4;
    localparam logic [3:0]   CTRL_RESET    = 4'h0;

    localparam int           EV_MISMATCH   = 0;
    localparam int           EV_IDLE_UNEQUIPPED_SIGNAL       = 1;
    localparam int           EV_CHANGED    = 2;
    localparam logic [2:0]   EV_RESET      = 3'h0;

    localparam logic         HEADER_MARK   = 1'b1;
    localparam logic         ID_MARK       = 1'b0;
    localparam logic [6:0]   CRC_POLY      = 7'h09;
    localparam logic [7:0]   LABEL_IDLE_UNEQUIPPED_SIGNAL    = 8'h00;
    localparam logic [7:0]   BYTE_ZERO     = 8'h00;
    localparam logic [3:0]   LAST_POS      = 4'hf;

    typedef enum logic [1:0] {
        TX_NORMAL      = 2'b00,
        TX_SUPERVISORY = 2'b01,
        TX_UNEQUIPPED  = 2'b11
    } tx_mode_t;

endpackage : trace_sup_pkg

// File: trail_trace_and_unequipped_supervision.sv
/*
 * Trail trace insertion and checking with unequipped supervision, reached
 * over an AHB-Lite slave with sticky event status and one interrupt.
 * Assumes frame strobes are one-cycle pulses on hclk and bus inputs are
 * synchronous to hclk.
 */
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module trail_trace_and_unequipped_supervision (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             irq,
    input  wire logic        tx_frame_en,
    input  wire logic [7:0]  client_signal_label,
    input  wire logic [7:0]  client_operator_byte,
    input  wire logic        client_remote_defect,
    input  wire logic        client_remote_error,
    output logic [7:0]       tx_trace_byte,
    output logic [7:0]       tx_trail_signal_label,
    output logic [7:0]       tx_operator_byte,
    output logic             tx_remote_defect_indication,
    output logic             tx_remote_error_indication,
    output logic             tx_idle_unequipped_signal,
    input  wire logic        rx_frame_en,
    input  wire logic [7:0]  rx_trace_byte,
    input  wire logic [7:0]  rx_trail_signal_label,
    input  wire logic        rx_remote_defect_indication,
    input  wire logic        rx_remote_error_indication,
    input  wire logic        rx_parity_error,
    output logic             trace_mismatch_report,
    output logic             remote_defect_report,
    output logic             signal_loss_unequipped,
    output logic             far_end_error_pulse
);

    localparam int N = trace_sup_pkg::TRACE_LEN;

    logic [trace_sup_pkg::CTRL_W-1:0] ctrl_q;
    logic [trace_sup_pkg::EV_W-1:0]   status_q;
    logic [trace_sup_pkg::EV_W-1:0]   mask_q;
    logic [7:0]                       tx_trace_q [N];
    logic [7:0]                       expected_trace_q [N];
    logic [7:0]                       transmitted_trace [N];
    logic [trace_sup_pkg::ID_BITS-1:0] id_bits;
    logic [trace_sup_pkg::CRC_W-1:0]  header_crc;
    logic                             wr_pend_q;
    logic                             rd_pend_q;
    logic [5:0]                       word_q;
    logic [31:0]                      rd_word;
    logic                             addr_phase;
    logic [3:0]                       tx_pos_q;
    trace_sup_pkg::tx_mode_t          tx_mode_q;
    trace_sup_pkg::tx_mode_t          tx_mode_d;
    logic                             unequipped_q;
    logic                             mismatch_raw;
    logic                             mismatch_q;
    logic                             rdi_q;
    logic [trace_sup_pkg::EV_W-1:0]   ev_set;
    logic                             wr_status;
    logic                             expect_on;

    trace_rx_if rx_if ();

    // Bus slave: zero wait states, always OKAY
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign addr_phase = hsel & hready & htrans[1];
    assign expect_on  = ctrl_q[trace_sup_pkg::CTRL_EXPECT];

    // Identifier bytes lose their MSB and the header is rebuilt by hardware
    genvar g;
    generate
        for (g = 1; g < N; g++) begin : g_tx_bytes
            assign transmitted_trace[g]               = {trace_sup_pkg::ID_MARK, tx_trace_q[g][6:0]};
            assign id_bits[(N-1-g)*8 +: 8]            = transmitted_trace[g];
        end
    endgenerate
    assign transmitted_trace[0] = {trace_sup_pkg::HEADER_MARK, header_crc};

    trace_crc7 u_crc (
        .identifier (id_bits),
        .crc        (header_crc)
    );

    assign rx_if.frame_en    = rx_frame_en;
    assign rx_if.trace_byte  = rx_trace_byte;
    assign rx_if.repeat_mode = ~expect_on;

    trace_rx_capture u_capture (
        .hclk    (hclk),
        .hresetn (hresetn),
        .rx      (rx_if.capture)
    );

    function automatic logic [31:0] pack_word(input logic [7:0] b0, input logic [7:0] b1,
                                              input logic [7:0] b2, input logic [7:0] b3);
        return {b3, b2, b1, b0};
    endfunction : pack_word

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            word_q    <= 6'h00;
        end else begin
            wr_pend_q <= addr_phase & hwrite;
            rd_pend_q <= addr_phase & ~hwrite;
            if (addr_phase) begin
                word_q <= haddr[7:2];
            end
        end
    end

    // Read data is sampled in the address phase; writes land one cycle later
    always_comb begin
        rd_word = 32'h0000_0000;
        case (haddr[7:2])
            trace_sup_pkg::IDX_CTRL:   rd_word[trace_sup_pkg::CTRL_W-1:0] = ctrl_q;
            trace_sup_pkg::IDX_STATUS: rd_word[trace_sup_pkg::EV_W-1:0]   = status_q;
            trace_sup_pkg::IDX_MASK:   rd_word[trace_sup_pkg::EV_W-1:0]   = mask_q;
            trace_sup_pkg::IDX_STATE:  rd_word[7:0] = {tx_pos_q, tx_idle_unequipped_signal,
                                                       remote_defect_report, unequipped_q,
                                                       trace_mismatch_report};
            default: begin
                for (int w = 0; w < trace_sup_pkg::TRACE_WORDS; w++) begin
                    if (haddr[7:2] == trace_sup_pkg::IDX_TX_BASE + 6'(w)) begin
                        rd_word = pack_word(transmitted_trace[4*w], transmitted_trace[4*w+1],
                                            transmitted_trace[4*w+2], transmitted_trace[4*w+3]);
                    end
                    if (haddr[7:2] == trace_sup_pkg::IDX_EXP_BASE + 6'(w)) begin
                        rd_word = pack_word(expected_trace_q[4*w], expected_trace_q[4*w+1],
                                            expected_trace_q[4*w+2], expected_trace_q[4*w+3]);
                    end
                    if (haddr[7:2] == trace_sup_pkg::IDX_ACC_BASE + 6'(w)) begin
                        rd_word = pack_word(rx_if.accepted[4*w], rx_if.accepted[4*w+1],
                                            rx_if.accepted[4*w+2], rx_if.accepted[4*w+3]);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase & ~hwrite) begin
            hrdata <= rd_word;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= trace_sup_pkg::CTRL_RESET;
            mask_q <= trace_sup_pkg::EV_RESET;
        end else if (wr_pend_q) begin
            if (word_q == trace_sup_pkg::IDX_CTRL) begin
                ctrl_q <= hwdata[trace_sup_pkg::CTRL_W-1:0];
            end
            if (word_q == trace_sup_pkg::IDX_MASK) begin
                mask_q <= hwdata[trace_sup_pkg::EV_W-1:0];
            end
        end
    end

    // Byte 0 of the transmitted trace is not stored: hardware owns the header
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < N; i++) begin
                tx_trace_q[i]       <= trace_sup_pkg::BYTE_ZERO;
                expected_trace_q[i] <= trace_sup_pkg::BYTE_ZERO;
            end
        end else if (wr_pend_q) begin
            for (int w = 0; w < trace_sup_pkg::TRACE_WORDS; w++) begin
                for (int b = 0; b < 4; b++) begin
                    if (word_q == trace_sup_pkg::IDX_TX_BASE + 6'(w) && (4*w + b) != 0) begin
                        tx_trace_q[4*w+b] <= hwdata[8*b +: 8];
                    end
                    if (word_q == trace_sup_pkg::IDX_EXP_BASE + 6'(w)) begin
                        expected_trace_q[4*w+b] <= hwdata[8*b +: 8];
                    end
                end
            end
        end
    end

    // Sink side: zero label is loss of signal, covers supervisory too
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unequipped_q <= 1'b0;
            rdi_q        <= 1'b0;
        end else if (rx_frame_en) begin
            unequipped_q <= rx_trail_signal_label == trace_sup_pkg::LABEL_IDLE_UNEQUIPPED_SIGNAL;
            rdi_q        <= rx_remote_defect_indication;
        end
    end

    always_comb begin
        mismatch_raw = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (rx_if.accepted[i] != expected_trace_q[i]) begin
                mismatch_raw = expect_on;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mismatch_q <= 1'b0;
        end else begin
            mismatch_q <= mismatch_raw;
        end
    end

    assign signal_loss_unequipped = unequipped_q;
    assign trace_mismatch_report  = mismatch_q & ~unequipped_q;
    assign remote_defect_report   = rdi_q & ~unequipped_q;

    // Far-end counts are meaningless while unequipped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            far_end_error_pulse <= 1'b0;
        end else begin
            far_end_error_pulse <= rx_frame_en & rx_remote_error_indication
                                 & ~(rx_trail_signal_label == trace_sup_pkg::LABEL_IDLE_UNEQUIPPED_SIGNAL);
        end
    end

    // Events: set wins over a write-one clear in the same cycle
    assign ev_set[trace_sup_pkg::EV_MISMATCH] = trace_mismatch_report;
    assign ev_set[trace_sup_pkg::EV_IDLE_UNEQUIPPED_SIGNAL]     = unequipped_q;
    assign ev_set[trace_sup_pkg::EV_CHANGED]  = rx_if.changed;
    assign wr_status = wr_pend_q && word_q == trace_sup_pkg::IDX_STATUS;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= trace_sup_pkg::EV_RESET;
        end else begin
            status_q <= (status_q & ~({trace_sup_pkg::EV_W{wr_status}} & hwdata[trace_sup_pkg::EV_W-1:0]))
                      | ev_set;
        end
    end

    assign irq = |(status_q & mask_q);

    // Source side: container choice taken once per trace string, at the last byte
    always_comb begin
        if (ctrl_q[trace_sup_pkg::CTRL_CONNECT] && ctrl_q[trace_sup_pkg::CTRL_INSTALL]) begin
            tx_mode_d = trace_sup_pkg::TX_NORMAL;
        end else if (ctrl_q[trace_sup_pkg::CTRL_SUPER]) begin
            tx_mode_d = trace_sup_pkg::TX_SUPERVISORY;
        end else begin
            tx_mode_d = trace_sup_pkg::TX_UNEQUIPPED;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_pos_q  <= 4'h0;
            tx_mode_q <= trace_sup_pkg::TX_UNEQUIPPED;
        end else if (tx_frame_en) begin
            tx_pos_q <= (tx_pos_q == trace_sup_pkg::LAST_POS) ? 4'h0 : tx_pos_q + 4'h1;
            if (tx_pos_q == trace_sup_pkg::LAST_POS) begin
                // Mode changes only at a string boundary so no trace is cut short
                tx_mode_q <= tx_mode_d;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_trace_byte               <= trace_sup_pkg::BYTE_ZERO;
            tx_trail_signal_label       <= trace_sup_pkg::LABEL_IDLE_UNEQUIPPED_SIGNAL;
            tx_operator_byte            <= trace_sup_pkg::BYTE_ZERO;
            tx_remote_defect_indication <= 1'b0;
            tx_remote_error_indication  <= 1'b0;
            tx_idle_unequipped_signal   <= 1'b1;
        end else if (tx_frame_en) begin
            case (tx_mode_q)
                trace_sup_pkg::TX_NORMAL: begin
                    tx_trace_byte               <= transmitted_trace[tx_pos_q];
                    tx_trail_signal_label       <= client_signal_label;
                    tx_operator_byte            <= client_operator_byte;
                    tx_remote_defect_indication <= client_remote_defect;
                    tx_remote_error_indication  <= client_remote_error;
                    tx_idle_unequipped_signal   <= 1'b0;
                end
                trace_sup_pkg::TX_SUPERVISORY: begin
                    tx_trace_byte               <= transmitted_trace[tx_pos_q];
                    tx_trail_signal_label       <= trace_sup_pkg::LABEL_IDLE_UNEQUIPPED_SIGNAL;
                    tx_operator_byte            <= trace_sup_pkg::BYTE_ZERO;
                    tx_remote_defect_indication <= unequipped_q | mismatch_q;
                    tx_remote_error_indication  <= rx_parity_error & ~unequipped_q;
                    tx_idle_unequipped_signal   <= 1'b1;
                end
                default: begin
                    tx_trace_byte               <= trace_sup_pkg::BYTE_ZERO;
                    tx_trail_signal_label       <= trace_sup_pkg::LABEL_IDLE_UNEQUIPPED_SIGNAL;
                    tx_operator_byte            <= trace_sup_pkg::BYTE_ZERO;
                    tx_remote_defect_indication <= 1'b0;
                    tx_remote_error_indication  <= 1'b0;
                    tx_idle_unequipped_signal   <= 1'b1;
                end
            endcase
        end
    end

endmodule : trail_trace_and_unequipped_supervision

// File: trail_trace_and_unequipped_supervision_test.sv
/* Bench: AHB-Lite register tasks, transmit frame strobes, remote source model.
   Assumes the designer's register map and zero-wait slave. */
`timescale 1ns/10ps
module trail_trace_and_unequipped_supervision_test;
    logic         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp, irq;
    logic         tx_frame_en = 1'b0, rx_rdi = 1'b0, rx_rei = 1'b0, run = 1'b0, rx_frame_en, tx_idle, tx_rdi;
    logic         trace_mismatch_report, remote_defect_report, signal_loss_unequipped;
    logic [1:0]   htrans = 2'h0;
    logic [7:0]   haddr = 8'h00, lab = 8'h13, rx_byte, rx_lab = 8'h13, tx_trace_byte;
    logic [31:0]  hwdata = 32'h0, hrdata, d;
    logic [127:0] str, bad, ptrace = 128'h0;
    logic [3:0]   md [4] = '{4'h7, 4'h9, 4'h0, 4'h5};
    int           err_count = 0, n_tests = 0, cyc = 0;
    assign hready = hreadyout;
    always #4 hclk = ~hclk;
    trail_trace_and_unequipped_supervision dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq, .tx_frame_en, .client_signal_label(lab),
        .client_operator_byte(8'h5c), .client_remote_defect(lab[4]), .client_remote_error(1'b0), .tx_trace_byte,
        .tx_trail_signal_label(), .tx_operator_byte(), .tx_remote_defect_indication(tx_rdi),
        .tx_remote_error_indication(), .tx_idle_unequipped_signal(tx_idle), .rx_frame_en, .rx_trace_byte(rx_byte),
        .rx_trail_signal_label(rx_lab), .rx_remote_defect_indication(rx_rdi), .rx_remote_error_indication(rx_rei),
        .rx_parity_error(1'b0), .trace_mismatch_report, .remote_defect_report, .signal_loss_unequipped,
        .far_end_error_pulse());
    remote_source far (.hclk, .hresetn, .run, .trace(ptrace), .frame_en(rx_frame_en), .tbyte(rx_byte));
    function automatic logic [6:0] crc7(input logic [127:0] s);
        logic [6:0] r;
        r = 7'h00;
        for (int i = 0; i < 128; i++) r = {r[5:0], 1'b0} ^ ((s[8*(i/8) + 7 - i%8] ^ r[6]) ? 7'h09 : 7'h00);
        return r;
    endfunction : crc7
    task automatic final_report();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        d = hrdata;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, d);
    endtask : rd
    task automatic txf();
        tx_frame_en <= 1'b1;
        @(posedge hclk);
        tx_frame_en <= 1'b0;
        @(posedge hclk);
    endtask : txf
    task automatic send(input logic [127:0] t, input logic [7:0] l);
        ptrace <= t;
        rx_lab <= l;
        run <= 1'b1;
        repeat (140) @(posedge hclk);
        run <= 1'b0;
        repeat (8) @(posedge hclk);
    endtask : send
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        str = 128'h0;
        for (int k = 1; k < 16; k++) str[8*k +: 8] = 8'h40 + 8'(k);
        str[7:0] = {1'b1, crc7(str | 128'h80)};
        bad = str ^ (128'h1 << 40);
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(8'h00, 32'h0);
        rd(8'h0c, 32'h8);
        bus(1'b1, 8'h40, 32'hffffffff);
        rd(8'h40, 32'h0);
        for (int k = 0; k < 4; k++) bus(1'b1, 8'h10 + 8'(4*k), str[32*k +: 32] | 32'h80808080);
        for (int k = 0; k < 4; k++) rd(8'h10 + 8'(4*k), str[32*k +: 32]);
        for (int m = 0; m < 4; m++) begin
            lab <= 8'h10 + 8'(m);
            bus(1'b1, 8'h00, {28'h0, md[m]});
            repeat (16) txf();
            for (int k = 0; k < 16; k++) begin
                txf();
                chk("tx byte", m < 2 ? 32'(str[8*k +: 8]) : 32'h0, 32'(tx_trace_byte));
            end
            chk("tx idle rdi", 32'({m != 0, m == 0}), 32'({tx_idle, tx_rdi}));
        end
        for (int k = 0; k < 4; k++) bus(1'b1, 8'h20 + 8'(4*k), str[32*k +: 32]);
        bus(1'b1, 8'h08, 32'h1);
        send(str, 8'h13);
        for (int k = 0; k < 4; k++) rd(8'h30 + 8'(4*k), str[32*k +: 32]);
        bus(1'b1, 8'h04, 32'h7);
        rd(8'h04, 32'h0);
        chk("irq", 32'h0, 32'(irq));
        send(bad, 8'h13);
        chk("mismatch", 32'h1, 32'(trace_mismatch_report));
        chk("irq", 32'h1, 32'(irq));
        rd(8'h04, 32'h5);
        bus(1'b1, 8'h08, 32'h2);
        @(posedge hclk);
        chk("irq", 32'h0, 32'(irq));
        rx_rdi <= 1'b1;
        rx_rei <= 1'b1;
        send(bad, 8'h00);
        chk("idle_unequipped_signal", 32'h1, 32'(signal_loss_unequipped));
        chk("reports", 32'h0, 32'({trace_mismatch_report, remote_defect_report}));
        chk("irq", 32'h1, 32'(irq));
        send(bad, 8'h13);
        chk("rdi", 32'h1, 32'(remote_defect_report));
        bus(1'b1, 8'h00, 32'h4);
        send({16{8'h2a}}, 8'h13);
        for (int k = 0; k < 4; k++) rd(8'h30 + 8'(4*k), 32'h2a2a2a2a);
        chk("mismatch", 32'h0, 32'(trace_mismatch_report));
        final_report();
    end
endmodule : trail_trace_and_unequipped_supervision_test
